/* rtl/drive_fault_supervisor.sv */
// drive fault supervisor: ground fault, low current, fault log, fire mode, wishbone registers
// What this block does
// R1: imbalance over level past filter trips, cuts output
// R2: four stamps, day 0..65535, minute 0..1439
// R3: six fault codes, newest first, empty reads zero
// R4: newest stamp is run time, shifts with code
// R5: low current past detection time applies response
// R6: response 0 none, 1 coast, 2 ramp2, 3 run
// R7: function 44 output shows low current detected
// R8: no low current detection in sleep, standby
// R9: threshold is rated current times percentage
// R10: fire selection 0 off, 1 forward, 2 reverse
// R11: fire uses inputs 58/59, outputs 53/54
// R12: fire mode runs at fire frequency, default 60Hz
// R13: one bit enables bypass to mains
// R14: reset count limit 0..10, window default 60s
// R15: bypass decision uses enable, delay, count, window
// R16: motion bit0 open/closed loop, bit1 manual/auto; here F_LOOP is bit 1, F_AUTO bit 2
// R17: fire selected and input 58 or 59 on enters fire
// R18: stamp taken from running minute/day counter
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`include "dfs_map.svh"
module drive_fault_supervisor
	import dfs_pkg::*;
#(
	parameter int TICK_CYC  = `TICK_CYC,
	parameter int MIN_TICKS = `MIN_TICKS
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	// measurements and events from drive logic, 0.1 A units
	input  wire logic [15:0] cur_u_i,
	input  wire logic [15:0] cur_v_i,
	input  wire logic [15:0] cur_w_i,
	input  wire logic [15:0] out_cur_i,
	input  wire logic        run_i,
	input  wire logic        fault_valid_i,
	input  wire logic [7:0]  fault_code_i,
	// pins
	input  wire logic        sleep_i,
	input  wire logic        standby_i,
	input  wire logic        fire_in58_i,
	input  wire logic        fire_in59_i,
	// protection outputs
	output logic             ground_fault_trip_o,
	output logic             low_current_output_function_o,
	output logic             lc_warn_o,
	output logic             lc_coast_o,
	output logic             lc_ramp2_o,
	// fire mode outputs and interrupt
	output logic             fire_active_o,
	output logic             fire_rev_o,
	output logic             fire_pid_o,
	output logic      [15:0] fire_freq_o,
	output logic             bypass_o,
	output logic             irq_o
);
	initial if (TICK_CYC < 2 || MIN_TICKS < 2 || TICK_CYC > 2**24 || MIN_TICKS > 2**16)
		$error("timebase parameter out of range");
	// pin synchronisers, a change counts once stages two and three agree
	logic [3:0] s1_ff, s2_ff, s3_ff, pin_ff;
	wire  [3:0] pin_raw = {fire_in59_i, fire_in58_i, standby_i, sleep_i};
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_ff[g]  <= 1'b0;
					s2_ff[g]  <= 1'b0;
					s3_ff[g]  <= 1'b0;
					pin_ff[g] <= 1'b0;
				end else begin
					s1_ff[g] <= pin_raw[g];
					s2_ff[g] <= s1_ff[g];
					s3_ff[g] <= s2_ff[g];
					if (s2_ff[g] == s3_ff[g]) pin_ff[g] <= s3_ff[g];
				end
			end
		end
	endgenerate
	wire idle_state = pin_ff[0] | pin_ff[1];
	wire fire_trig = pin_ff[2] | pin_ff[3]; // R11
	logic [15:0] gf_level_ff, gf_filt_ff, lc_time_ff, rated_ff, fire_freq_ff, byp_dly_ff, rst_win_ff;
	logic [9:0]  lc_level_ff;
	logic [1:0]  lc_resp_ff, fire_sel_ff;
	logic [7:0]  fire_cfg_ff;
	logic [3:0]  status_ff, mask_ff;
	// timebase: 10 ms tick, 0.1 s tick, run time minutes and days
	logic [23:0] tick_cnt_ff;
	logic [15:0] mtick_ff, day_ff;
	logic [10:0] min_ff;
	logic [3:0]  deci_cnt_ff;
	wire tick = tick_cnt_ff == 24'(TICK_CYC - 1);
	wire deci = tick && deci_cnt_ff == 4'(`DECI_TICKS - 1);
	wire min_step = tick && run_i && mtick_ff == 16'(MIN_TICKS - 1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_ff <= 24'h000000;
			deci_cnt_ff <= 4'h0;
			mtick_ff <= 16'h0000;
			min_ff <= 11'h000;
			day_ff <= 16'h0000;
		end else begin
			tick_cnt_ff <= tick ? 24'h000000 : tick_cnt_ff + 24'h000001;
			if (tick) deci_cnt_ff <= deci ? 4'h0 : deci_cnt_ff + 4'h1;
			if (tick && run_i) mtick_ff <= min_step ? 16'h0000 : mtick_ff + 16'h0001;
			if (min_step) begin
				min_ff <= (min_ff == `MIN_LAST) ? 11'h000 : min_ff + 11'h001; // R18
				if (min_ff == `MIN_LAST) day_ff <= day_ff + 16'h0001; // R18
			end
		end
	end
	// ground fault on phase imbalance, max minus min against rated times level
	wire [15:0] i_max = (cur_u_i > cur_v_i) ? ((cur_u_i > cur_w_i) ? cur_u_i : cur_w_i)
	                                        : ((cur_v_i > cur_w_i) ? cur_v_i : cur_w_i);
	wire [15:0] i_min = (cur_u_i < cur_v_i) ? ((cur_u_i < cur_w_i) ? cur_u_i : cur_w_i)
	                                        : ((cur_v_i < cur_w_i) ? cur_v_i : cur_w_i);
	wire [31:0] gf_lhs = 32'(i_max - i_min) * `PERMILLE;
	wire [31:0] gf_rhs = 32'(rated_ff) * 32'(gf_level_ff);
	wire        gf_over = gf_lhs > gf_rhs;
	logic [15:0] gf_cnt_ff;
	logic        gf_trip_ff;
	wire         gf_fire = gf_over && gf_cnt_ff >= gf_filt_ff && !gf_trip_ff;
	logic        clr_gf, clr_fire;
	// low current, threshold is rated current times percentage in 0.1 % steps
	wire [31:0] lc_lhs = 32'(out_cur_i) * `PERMILLE;
	wire [31:0] lc_rhs = 32'(rated_ff) * 32'(lc_level_ff); // R9
	wire        lc_under = lc_lhs < lc_rhs;
	logic [15:0] lc_cnt_ff;
	logic        lc_det_ff;
	wire         lc_hit = lc_under && lc_cnt_ff > lc_time_ff && !idle_state; // R5
	always_ff @(posedge clk_i) begin
		if (rst_i || !gf_over) gf_cnt_ff <= 16'h0000;
		else if (tick && gf_cnt_ff != 16'hffff) gf_cnt_ff <= gf_cnt_ff + 16'h0001;
		if (rst_i) gf_trip_ff <= 1'b0;
		else if (gf_fire) gf_trip_ff <= 1'b1; // R1
		else if (clr_gf) gf_trip_ff <= 1'b0;
		// sleep or standby holds detection off entirely
		if (rst_i || !lc_under || idle_state) lc_cnt_ff <= 16'h0000; // R8
		else if (tick && lc_cnt_ff != 16'hffff) lc_cnt_ff <= lc_cnt_ff + 16'h0001;
		if (rst_i) lc_det_ff <= 1'b0;
		else lc_det_ff <= lc_hit; // R5
	end
	// fault logging: internal ground fault trip wins a shared cycle
	wire       push = gf_fire || fault_valid_i;
	wire [7:0] push_code = gf_fire ? `GF_CODE : fault_code_i;
	logic [15:0] log_rd;
	fault_log #(.DEPTH(6), .STAMPS(4)) u_log (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.push_i    (push),
		.code_i    (push_code), // R3
		.day_i     (day_ff), // R4
		.min_i     (min_ff),
		.rd_addr_i (wb_adr_i[5:2]),
		.rd_data_o (log_rd)
	);
	// fire mode state machine with bypass decision
	fire_state_e fs_ff, nxt_fs;
	logic [3:0]  rst_cnt_ff;
	logic [15:0] byp_cnt_ff, win_cnt_ff;
	logic        byp_pend_ff;
	wire fire_sel_ok = fire_sel_ff == FM_FWD || fire_sel_ff == FM_REV; // R10
	wire auto_rst = fire_cfg_ff[`F_AUTO]; // R16
	wire fire_exit = auto_rst ? !fire_trig : clr_fire;
	wire in_fire = fs_ff == FS_FIRE;
	wire fire_fault = in_fire && fault_valid_i;
	wire byp_go = fire_cfg_ff[`F_BYP] && ((byp_pend_ff && byp_cnt_ff >= byp_dly_ff)
	              || rst_cnt_ff > fire_cfg_ff[`F_LIM +: 4]); // R15
	always_comb begin
		nxt_fs = fs_ff;
		unique case (fs_ff)
			FS_IDLE: if (fire_sel_ok && fire_trig) nxt_fs = FS_FIRE; // R17
			FS_FIRE: begin
				if (fire_exit)
					nxt_fs = FS_IDLE;
				else if (byp_go)
					nxt_fs = FS_BYP; // R13
			end
			FS_BYP: if (fire_exit) nxt_fs = FS_IDLE;
			default: nxt_fs = FS_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs_ff <= FS_IDLE;
			byp_pend_ff <= 1'b0;
			byp_cnt_ff <= 16'h0000;
			rst_cnt_ff <= 4'h0;
			win_cnt_ff <= 16'h0000;
		end else begin
			fs_ff <= nxt_fs;
			if (!in_fire) begin
				byp_pend_ff <= 1'b0;
				byp_cnt_ff <= 16'h0000;
				rst_cnt_ff <= 4'h0;
				win_cnt_ff <= 16'h0000;
			end else begin
				if (fire_fault) byp_pend_ff <= 1'b1;
				if (byp_pend_ff && deci && byp_cnt_ff != 16'hffff) byp_cnt_ff <= byp_cnt_ff + 16'h0001;
				// count of unusual resets restarts when its window runs out
				if (deci && win_cnt_ff >= rst_win_ff) begin
					win_cnt_ff <= 16'h0000;
					rst_cnt_ff <= 4'h0; // R14
				end else begin
					if (deci) win_cnt_ff <= win_cnt_ff + 16'h0001;
					if (fire_fault && rst_cnt_ff != 4'hf) rst_cnt_ff <= rst_cnt_ff + 4'h1; // R14
				end
			end
		end
	end
	// wishbone: request seen, log read lands, ack two edges later; writes land on the ack edge
	logic pend_ff;
	wire  req = wb_cyc_i && wb_stb_i && !pend_ff && !wb_ack_o;
	wire  wr = wb_ack_o && wb_we_i;
	wire  rd = pend_ff && !wb_we_i;
	wire  log_hit = wb_adr_i[7:6] == `LOG_REGION;
	wire  [3:0] st_clr = (rd && wb_adr_i == `A_STATUS) ? status_ff : 4'h0;
	wire  gf_rise = gf_fire;
	wire  lc_rise = lc_hit && !lc_det_ff;
	wire  [3:0] ev = {nxt_fs == FS_BYP && fs_ff != FS_BYP, nxt_fs == FS_FIRE && fs_ff == FS_IDLE, lc_rise, gf_rise};
	wire  [3:0] nxt_status = (status_ff & ~st_clr) | ev;
	wire  [31:0] wd = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign clr_gf = wr && wb_adr_i == `A_CMD && wd[`C_CLR_GF];
	assign clr_fire = wr && wb_adr_i == `A_CMD && wd[`C_CLR_FIRE];
	wire [31:0] live = {26'h0, bypass_o, fire_active_o, idle_state, fire_trig, lc_det_ff, gf_trip_ff};
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h00000000;
		if (log_hit) rdata = {16'h0000, log_rd};
		else
			unique case (wb_adr_i)
				`A_GF_LEVEL: rdata = {16'h0000, gf_level_ff};
				`A_GF_FILT: rdata = {16'h0000, gf_filt_ff};
				`A_LC_LEVEL: rdata = {22'h000000, lc_level_ff};
				`A_LC_TIME: rdata = {16'h0000, lc_time_ff};
				`A_LC_RESP: rdata = {30'h00000000, lc_resp_ff};
				`A_RATED: rdata = {16'h0000, rated_ff};
				`A_FIRE_SEL: rdata = {30'h00000000, fire_sel_ff};
				`A_FIRE_FREQ: rdata = {16'h0000, fire_freq_ff};
				`A_FIRE_CFG: rdata = {24'h000000, fire_cfg_ff};
				`A_BYP_DLY: rdata = {16'h0000, byp_dly_ff};
				`A_RST_WIN: rdata = {16'h0000, rst_win_ff};
				`A_STATUS: rdata = {28'h0000000, status_ff};
				`A_MASK: rdata = {28'h0000000, mask_ff};
				`A_LIVE: rdata = live;
				`A_RUNTIME: rdata = {day_ff, 5'h00, min_ff};
				default: rdata = 32'h00000000;
			endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_ff <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			status_ff <= 4'h0;
		end else begin
			pend_ff <= req;
			wb_ack_o <= pend_ff;
			wb_dat_o <= rd ? rdata : 32'h00000000;
			status_ff <= nxt_status; // event set wins over read clear
		end
	end
	// range limits of the settings are left to software; the logic serves any value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gf_level_ff <= `R_GF_LEVEL;
			gf_filt_ff <= `R_GF_FILT;
			lc_level_ff <= `R_LC_LEVEL;
			lc_time_ff <= `R_LC_TIME;
			lc_resp_ff <= LC_NONE;
			rated_ff <= `R_RATED;
			fire_sel_ff <= FM_OFF;
			fire_freq_ff <= `R_FIRE_FREQ;
			fire_cfg_ff <= `R_FIRE_CFG;
			byp_dly_ff <= `R_BYP_DLY;
			rst_win_ff <= `R_RST_WIN;
			mask_ff <= 4'h0;
		end else if (wr) begin
			if (wb_adr_i == `A_GF_LEVEL) gf_level_ff <= wd[15:0];
			if (wb_adr_i == `A_GF_FILT) gf_filt_ff <= wd[15:0];
			if (wb_adr_i == `A_LC_LEVEL) lc_level_ff <= wd[9:0];
			if (wb_adr_i == `A_LC_TIME) lc_time_ff <= wd[15:0];
			if (wb_adr_i == `A_LC_RESP) lc_resp_ff <= wd[1:0];
			if (wb_adr_i == `A_RATED) rated_ff <= wd[15:0];
			if (wb_adr_i == `A_FIRE_SEL) fire_sel_ff <= wd[1:0];
			if (wb_adr_i == `A_FIRE_FREQ) fire_freq_ff <= wd[15:0];
			if (wb_adr_i == `A_FIRE_CFG) fire_cfg_ff <= wd[7:0];
			if (wb_adr_i == `A_BYP_DLY) byp_dly_ff <= wd[15:0];
			if (wb_adr_i == `A_RST_WIN) rst_win_ff <= wd[15:0];
			if (wb_adr_i == `A_MASK) mask_ff <= wd[3:0];
		end
	end
	wire lc_act = lc_det_ff && lc_resp_ff != LC_NONE;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ground_fault_trip_o <= 1'b0;
			low_current_output_function_o <= 1'b0;
			lc_warn_o <= 1'b0;
			lc_coast_o <= 1'b0;
			lc_ramp2_o <= 1'b0;
			fire_active_o <= 1'b0;
			fire_rev_o <= 1'b0;
			fire_pid_o <= 1'b0;
			fire_freq_o <= 16'h0000;
			bypass_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			ground_fault_trip_o <= gf_trip_ff || gf_fire; // R1
			low_current_output_function_o <= lc_det_ff; // R7
			lc_warn_o <= lc_act; // R6
			lc_coast_o <= lc_act && lc_resp_ff == LC_COAST; // R6
			lc_ramp2_o <= lc_act && lc_resp_ff == LC_RAMP2; // R6
			fire_active_o <= in_fire; // R11
			fire_rev_o <= in_fire && fire_sel_ff == FM_REV; // R10
			fire_pid_o <= in_fire && fire_cfg_ff[`F_LOOP]; // R16
			fire_freq_o <= in_fire ? fire_freq_ff : 16'h0000; // R12
			bypass_o <= fs_ff == FS_BYP; // R11
			irq_o <= |(status_ff & mask_ff);
		end
	end
	property p_gf_trip;
		@(posedge clk_i) disable iff (rst_i) gf_over && gf_cnt_ff >= gf_filt_ff |=> ground_fault_trip_o;
	endproperty
	a_gf_trip: assert property (p_gf_trip) else $error("ground fault not tripped"); // R1
	property p_lc_sleep;
		@(posedge clk_i) disable iff (rst_i) idle_state |=> !lc_det_ff ##1 !low_current_output_function_o;
	endproperty
	a_lc_sleep: assert property (p_lc_sleep) else $error("low current detected in sleep"); // R8
	property p_lc_coast;
		@(posedge clk_i) disable iff (rst_i) lc_coast_o |-> $past(lc_resp_ff) == LC_COAST && $past(lc_det_ff);
	endproperty
	a_lc_coast: assert property (p_lc_coast) else $error("coast without response 1"); // R6
	property p_lc_time;
		@(posedge clk_i) disable iff (rst_i) $rose(lc_det_ff) |-> $past(lc_cnt_ff) > $past(lc_time_ff);
	endproperty
	a_lc_time: assert property (p_lc_time) else $error("low current before detection time"); // R5
	property p_fire_enter;
		@(posedge clk_i) disable iff (rst_i) fs_ff == FS_IDLE && fire_sel_ok && fire_trig |=> ##1 fire_active_o;
	endproperty
	a_fire_enter: assert property (p_fire_enter) else $error("fire mode not entered"); // R17
	property p_fire_freq;
		@(posedge clk_i) disable iff (rst_i) fire_active_o |-> fire_freq_o == $past(fire_freq_ff);
	endproperty
	a_fire_freq: assert property (p_fire_freq) else $error("wrong fire frequency"); // R12
	property p_fire_dir;
		@(posedge clk_i) disable iff (rst_i) fire_rev_o |-> $past(fire_sel_ff) == FM_REV;
	endproperty
	a_fire_dir: assert property (p_fire_dir) else $error("reverse without selection 2"); // R10
	property p_bypass;
		@(posedge clk_i) disable iff (rst_i) $rose(bypass_o) |-> $past(fire_cfg_ff[`F_BYP], 2);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass while disabled"); // R13
	c_gf: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ground_fault_trip_o));
	c_lc: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lc_ramp2_o));
	c_byp: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bypass_o));
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule

/* common/dfs_map.svh */
// register offsets, field positions, reset values and timing counts of the drive fault supervisor
`ifndef DFS_MAP_SVH
`define DFS_MAP_SVH
`define A_GF_LEVEL 8'h00
`define A_GF_FILT 8'h04
`define A_LC_LEVEL 8'h08
`define A_LC_TIME 8'h0c
`define A_LC_RESP 8'h10
`define A_RATED 8'h14
`define A_FIRE_SEL 8'h18
`define A_FIRE_FREQ 8'h1c
`define A_FIRE_CFG 8'h20
`define A_BYP_DLY 8'h24
`define A_RST_WIN 8'h28
`define A_STATUS 8'h2c
`define A_MASK 8'h30
`define A_LIVE 8'h34
`define A_CMD 8'h38
`define A_RUNTIME 8'h3c
`define LOG_REGION 2'b01
`define F_BYP 0
`define F_LOOP 1
`define F_AUTO 2
`define F_LIM 4
`define S_GF 0
`define S_LC 1
`define S_FIRE 2
`define S_BYP 3
`define C_CLR_GF 0
`define C_CLR_FIRE 1
`define R_GF_LEVEL 16'h0258
`define R_GF_FILT 16'h000a
`define R_LC_LEVEL 10'h000
`define R_LC_TIME 16'h0000
`define R_RATED 16'h0064
`define R_FIRE_FREQ 16'h1770
`define R_FIRE_CFG 8'h00
`define R_BYP_DLY 16'h0000
`define R_RST_WIN 16'h0258
`define GF_CODE 8'h04
`define PERMILLE 32'd1000
`define MIN_LAST 11'h59f
`define CLK_NS 10
`define TICK_MS 10
`define TICK_CYC (`TICK_MS * 1000000 / `CLK_NS)
`define MINUTE_MS 60000
`define MIN_TICKS (`MINUTE_MS / `TICK_MS)
`define DECI_MS 100
`define DECI_TICKS (`DECI_MS / `TICK_MS)
`endif

/* common/dfs_pkg.sv */
// types shared by the drive fault supervisor
package dfs_pkg;
	typedef enum logic [1:0] {LC_NONE, LC_COAST, LC_RAMP2, LC_RUN} lc_resp_e;
	typedef enum logic [1:0] {FM_OFF, FM_FWD, FM_REV, FM_BAD} fire_sel_e;
	typedef enum logic [1:0] {FS_IDLE, FS_FIRE, FS_BYP} fire_state_e;
endpackage

/* rtl/fault_log.sv */
// fault code history and time stamp memory with registered read port
`timescale 1ns/100ps
module fault_log #(
	parameter int DEPTH  = 6,
	parameter int STAMPS = 4
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// push side
	input  wire logic        push_i,
	input  wire logic [7:0]  code_i,
	input  wire logic [15:0] day_i,
	input  wire logic [10:0] min_i,
	// read side: 0..5 codes, 8+2j day j, 9+2j minute j
	input  wire logic [3:0]  rd_addr_i,
	output logic      [15:0] rd_data_o
);
	initial begin
		if (DEPTH > 8 || STAMPS > 4 || STAMPS > DEPTH)
			$error("fault_log depth out of range");
	end

	logic [7:0]  code_ff [DEPTH];
	logic [15:0] day_ff  [STAMPS];
	logic [10:0] min_ff  [STAMPS];

	// newest enters slot 0, the rest move down, slots 0..3 together with their stamps
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_code
			always_ff @(posedge clk_i) begin
				if (rst_i)
					code_ff[i] <= 8'h00;
				else if (push_i)
					code_ff[i] <= (i == 0) ? code_i : code_ff[(i == 0) ? 0 : i - 1]; // R3
			end
		end
		for (i = 0; i < STAMPS; i++) begin : g_stamp
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					day_ff[i] <= 16'h0000;
					min_ff[i] <= 11'h000;
				end else if (push_i) begin
					day_ff[i] <= (i == 0) ? day_i : day_ff[(i == 0) ? 0 : i - 1]; // R4
					min_ff[i] <= (i == 0) ? min_i : min_ff[(i == 0) ? 0 : i - 1]; // R2
				end
			end
		end
	endgenerate

	wire [2:0] rd_code_idx = rd_addr_i[2:0];
	wire [1:0] rd_st_idx = rd_addr_i[2:1];
	wire       code_hit = !rd_addr_i[3] && (int'(rd_code_idx) < DEPTH);
	wire       st_hit = rd_addr_i[3] && (int'(rd_st_idx) < STAMPS);
	wire [15:0] st_word = rd_addr_i[0] ? {5'h00, min_ff[rd_st_idx]} : day_ff[rd_st_idx];
	wire [15:0] nxt_rd = code_hit ? {8'h00, code_ff[rd_code_idx]} : (st_hit ? st_word : 16'h0000);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rd_data_o <= 16'h0000;
		else
			rd_data_o <= nxt_rd;
	end

	property p_shift;
		@(posedge clk_i) disable iff (rst_i) push_i |=> code_ff[1] == $past(code_ff[0]);
	endproperty
	a_shift: assert property (p_shift) else $error("history did not shift down"); // R3
	property p_stamp_shift;
		@(posedge clk_i) disable iff (rst_i) push_i |=> day_ff[1] == $past(day_ff[0]) && min_ff[1] == $past(min_ff[0]);
	endproperty
	a_stamp_shift: assert property (p_stamp_shift) else $error("stamp did not follow its code"); // R4
	property p_min_range;
		@(posedge clk_i) disable iff (rst_i) min_ff[0] <= 11'd1439;
	endproperty
	a_min_range: assert property (p_min_range) else $error("minute stamp out of range"); // R2
endmodule

/* test/drive_fault_supervisor_bench.sv */
// self-checking bench for the drive fault supervisor
`timescale 1ns/100ps
`include "dfs_map.svh"
module drive_fault_supervisor_bench;
	import dfs_pkg::*;
	typedef struct {logic chk; logic [7:0] adr; logic [31:0] exp;} note_s;
	// short counts so a minute is 200 cycles of running
	localparam int TICK = 20;
	localparam int MTK  = 10;
	localparam int MINC = TICK * MTK;
	logic        clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
	logic        run_i = '0, fault_valid_i = '0, sleep_i = '0, standby_i = '0, fire_in58_i = '0, fire_in59_i = '0;
	logic [7:0]  wb_adr_i = '0, fault_code_i = '0;
	logic [3:0]  wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o;
	logic [15:0] cur_u_i = '0, cur_v_i = '0, cur_w_i = '0, out_cur_i = '0, fire_freq_o, freq;
	logic        wb_ack_o, ground_fault_trip_o, low_current_output_function_o, lc_warn_o, lc_coast_o, lc_ramp2_o;
	logic        fire_active_o, fire_rev_o, fire_pid_o, bypass_o, irq_o;
	int          bad_count = 0, cmp_count = 0, mins = 0, dly;
	note_s       notes[$];
	logic [7:0]  codes[$];
	logic [10:0] stamps[$];
	lc_resp_e    resp;
	fire_sel_e   sel;
	drive_fault_supervisor #(.TICK_CYC(TICK), .MIN_TICKS(MTK)) i_drive_fault_supervisor (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
		.cur_u_i, .cur_v_i, .cur_w_i, .out_cur_i, .run_i, .fault_valid_i, .fault_code_i, .sleep_i, .standby_i,
		.fire_in58_i, .fire_in59_i, .ground_fault_trip_o, .low_current_output_function_o, .lc_warn_o,
		.lc_coast_o, .lc_ramp2_o, .fire_active_o, .fire_rev_o, .fire_pid_o, .fire_freq_o, .bypass_o, .irq_o);
	always #5 clk_i = ~clk_i;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// one classic cycle; the ack watcher compares read data against the note
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic c);
		int n;
		notes.push_back('{c, a, d});
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= we ? d : 32'h0;
		wb_sel_i <= 4'hf;
		for (n = 0; n < 20 && wb_ack_o !== 1'h1; n++) @(posedge clk_i);
		if (n == 0) @(posedge clk_i);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		if (wb_ack_o !== 1'h1) begin
			chk("bus ack", 1, 0);
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d, 1'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, e, 1'h1);
	endtask
	task automatic await(ref logic s, input logic v, input int lim, input string what);
		for (int n = 0; n < lim && s !== v; n++) @(posedge clk_i);
		chk(what, v, s);
		if (s !== v) test_done();
	endtask
	task automatic check_log;
		for (int k = 0; k < 6; k++) rd(8'h40 + 8'(4 * k), k < codes.size() ? 32'(codes[k]) : 32'h0);
		for (int k = 0; k < 4; k++) begin
			rd(8'h60 + 8'(8 * k), 32'h0);
			rd(8'h64 + 8'(8 * k), k < stamps.size() ? 32'(stamps[k]) : 32'h0);
		end
		rd(`A_RUNTIME, 32'(mins));
	endtask
	always @(posedge clk_i) begin
		note_s nt;
		if (wb_ack_o === 1'h1) begin
			if (notes.size() == 0) chk("stray ack", 0, 1);
			else begin
				nt = notes.pop_front();
				if (nt.chk) chk($sformatf("read %h", nt.adr), nt.exp, wb_dat_o);
			end
		end
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		chk("run length", 0, 1);
		test_done();
	end
	initial begin
		void'($urandom(64271));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(`A_GF_LEVEL, 32'h258);
		rd(`A_GF_FILT, 32'ha);
		rd(`A_RATED, 32'h64);
		rd(`A_FIRE_FREQ, 32'h1770);
		rd(`A_RST_WIN, 32'h258);
		rd(`A_STATUS, 32'h0);
		rd(8'hfc, 32'h0);
		$display("test defaults done");
		// whole minutes of running, drive stopped while a fault is logged
		for (int i = 0; i < 7; i++) begin
			dly = $urandom_range(1, 4);
			run_i <= 1'h1;
			repeat (dly * MINC) @(posedge clk_i);
			run_i <= 1'h0;
			mins += dly;
			codes.push_front(8'($urandom_range(1, 255)));
			stamps.push_front(11'(mins));
			repeat (3) @(posedge clk_i);
			fault_code_i <= codes[0];
			fault_valid_i <= 1'h1;
			@(posedge clk_i);
			fault_valid_i <= 1'h0;
			if (i == 0 || i == 6) check_log();
		end
		$display("test fault log done");
		wr(`A_GF_FILT, 32'h3);
		wr(`A_MASK, 32'h1);
		cur_u_i <= 16'h3c;
		repeat (150) @(posedge clk_i);
		chk("trip at level", 0, ground_fault_trip_o);
		cur_u_i <= 16'h3d;
		repeat (30) @(posedge clk_i);
		chk("trip before filter", 0, ground_fault_trip_o);
		await(ground_fault_trip_o, 1'h1, 100, "trip");
		await(irq_o, 1'h1, 3, "trip irq");
		rd(`A_LIVE, 32'h1);
		rd(8'h40, 32'(`GF_CODE));
		rd(`A_STATUS, 32'h1);
		rd(`A_STATUS, 32'h0);
		await(irq_o, 1'h0, 3, "irq cleared");
		cur_u_i <= 16'h0;
		wr(`A_CMD, 32'h1);
		await(ground_fault_trip_o, 1'h0, 5, "trip cleared");
		$display("test ground fault done");
		wr(`A_LC_LEVEL, 32'h1f4);
		wr(`A_LC_TIME, 32'h2);
		out_cur_i <= 16'h32;
		for (int r = 0; r < 4; r++) begin
			resp = lc_resp_e'(r);
			wr(`A_LC_RESP, 32'(r));
			out_cur_i <= 16'h31;
			repeat (30) @(posedge clk_i);
			chk("low current early", 0, low_current_output_function_o);
			await(low_current_output_function_o, 1'h1, 200, "low current");
			repeat (2) @(posedge clk_i);
			chk("warn", resp != LC_NONE, lc_warn_o);
			chk("coast", resp == LC_COAST, lc_coast_o);
			chk("ramp2", resp == LC_RAMP2, lc_ramp2_o);
			out_cur_i <= 16'h32;
			await(low_current_output_function_o, 1'h0, 50, "low current gone");
		end
		rd(`A_STATUS, 32'h2);
		wr(`A_RATED, 32'hc8);
		for (int s = 0; s < 2; s++) begin
			{standby_i, sleep_i} <= 2'(1 << s);
			out_cur_i <= 16'h63;
			repeat (150) @(posedge clk_i);
			chk("low current asleep", 0, low_current_output_function_o);
			{standby_i, sleep_i} <= 2'h0;
			await(low_current_output_function_o, 1'h1, 200, "low current scaled");
			out_cur_i <= 16'h64;
			await(low_current_output_function_o, 1'h0, 50, "scaled gone");
		end
		$display("test low current done");
		freq = 16'($urandom_range(0, 59900));
		wr(`A_FIRE_FREQ, 32'(freq));
		wr(`A_FIRE_CFG, 32'ha6);
		for (int s = 0; s < 3; s++) begin
			sel = fire_sel_e'(s);
			wr(`A_FIRE_SEL, 32'(s));
			{fire_in59_i, fire_in58_i} <= s[0] ? 2'h1 : 2'h2;
			repeat (12) @(posedge clk_i);
			chk("fire active", sel != FM_OFF, fire_active_o);
			chk("fire reverse", sel == FM_REV, fire_rev_o);
			chk("fire loop", sel != FM_OFF, fire_pid_o);
			chk("fire freq", sel != FM_OFF ? freq : 16'h0, fire_freq_o);
			{fire_in59_i, fire_in58_i} <= 2'h0;
			await(fire_active_o, 1'h0, 12, "fire auto reset");
		end
		// bypass path: limit 10 keeps the reset count out, so only the delay decides
		wr(`A_FIRE_CFG, 32'ha1);
		wr(`A_BYP_DLY, 32'h2);
		fire_in58_i <= 1'h1;
		await(fire_active_o, 1'h1, 12, "fire entry");
		fire_in58_i <= 1'h0;
		fault_code_i <= 8'h1;
		fault_valid_i <= 1'h1;
		@(posedge clk_i);
		fault_valid_i <= 1'h0;
		repeat (100) @(posedge clk_i);
		chk("bypass early", 0, bypass_o);
		chk("open loop", 0, fire_pid_o);
		chk("manual hold", 1, fire_active_o);
		await(bypass_o, 1'h1, 400, "bypass");
		wr(`A_CMD, 32'h2);
		await(bypass_o, 1'h0, 12, "fire manual reset");
		$display("test fire mode done");
		test_done();
	end
endmodule
